// >>> design/rds_pkg.sv
package rds_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LAST_WORD = 8'h08;
  localparam logic [7:0] ADDR_LAST_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_NEXT_PTR = 8'h10;
  localparam logic [7:0] ADDR_BASE_PTR = 8'h14;

  // ----------------------------------------
  // configuration and status field positions
  // ----------------------------------------
  localparam int CFG_PURITY_BIT = 0;
  localparam int CFG_LONG_PREAMBLE_CHECK_BIT = 1;
  localparam int CFG_BUFFULL_BIT = 2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int STAT_OVERRUN_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // ----------------------------------------
  // descriptor status bit positions
  // ----------------------------------------
  localparam int ST_INTACT = 15;
  localparam int ST_ODD_NIBBLE = 14;
  localparam int ST_FCS_FAULT = 13;
  localparam int ST_LONG_DROP = 12;
  localparam int ST_PAUSE = 11;
  localparam int ST_CONTROL = 10;
  localparam int ST_MULTICAST = 9;
  localparam int ST_BROADCAST = 8;
  localparam int ST_TAGGED = 7;
  localparam int ST_UNK_OPCODE = 6;
  localparam int ST_LEN_RANGE = 5;
  localparam int ST_LEN_MISMATCH = 4;
  localparam int ST_CODE_VIOL = 3;
  localparam int ST_CARRIER = 2;
  localparam int ST_SHORT = 1;
  localparam int ST_OVERRUN = 0;

  // ----------------------------------------
  // frame constants
  // ----------------------------------------
  localparam logic [15:0] LONG_EVENT_BITS = 16'hC350;
  localparam logic [15:0] LONG_EVENT_NIBBLES = LONG_EVENT_BITS / 16'h0004;
  localparam logic [4:0] MAX_PREAMBLE_NIBBLES = 5'h16;
  localparam logic [4:0] MIN_GAP_NIBBLES = 5'h18;
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
  localparam logic [15:0] MAX_LENGTH_FIELD = 16'h05EE;
  localparam logic [15:0] LENGTH_TYPE_LIMIT = 16'h0600;
  localparam logic [15:0] TYPE_CONTROL = 16'h8808;
  localparam logic [15:0] TYPE_VLAN = 16'h8100;
  localparam logic [15:0] OPCODE_PAUSE = 16'h0001;
  localparam logic [15:0] HDR_AND_FCS = 16'h0012;
  localparam logic [3:0] CARRIER_CODE = 4'hE;
  localparam logic [3:0] SFD_NIBBLE = 4'hD;
  localparam logic [3:0] PRE_NIBBLE = 4'h5;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [2:0] DESC_BYTES = 3'h7;
  localparam logic [23:0] BASE_RESET = 24'h000000;

  typedef enum logic [4:0] {
    RDS_IDLE = 5'h01,
    RDS_PRE = 5'h02,
    RDS_DATA = 5'h04,
    RDS_DISCARD = 5'h08,
    RDS_WRITE = 5'h10
  } rds_state_t;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] data;
  } rds_mii_t;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [7:0] data;
  } rds_mem_t;

endpackage : rds_pkg

// >>> design/rds_rx_status.sv
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - bit 15 only for error-free complete frames
// - bit 14 on odd nibble count
// - bit 13 on check sequence mismatch
// - bit 12 when frame exceeds 50000 bits
// - bit 12 on short gap or impure preamble
// - bit 12 on preamble over 11 bytes
// - bit 11 for pause control frame
// - bit 10 for any control frame
// - bit 9 multicast, bit 8 broadcast
// - bit 7 for tagged frame
// - bit 6 for unknown control opcode
// - bit 5 when length field exceeds 1518
// - bit 4 when length differs from data
// - bit 3 on receive error in frame
// - bit 2 after earlier carrier event
// - bit 1 after earlier too-short activity
// - bit 0 on overrun with buffers full
// - discard frames until overrun flag cleared
// - seven-byte descriptor with 24-bit next pointer
// - byte count includes FCS, excludes descriptor
module rds_rx_status (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire rds_pkg::rds_mii_t i_mii,
  input wire logic i_fifo_full,
  output rds_pkg::rds_mem_t o_mem,
  output logic o_rx_done,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rds_pkg::rds_state_t fsm;
    logic [31:0] crc;
    logic [15:0] nib;
    logic [4:0] pre_nib;
    logic [4:0] gap;
    logic pre_impure;
    logic [3:0] lo_nib;
    logic [15:0] bytes;
    logic [7:0] b12;
    logic [15:0] len_type;
    logic [15:0] opcode;
    logic [15:0] st;
    logic carrier_seen;
    logic short_seen;
    logic overrun;
    logic [2:0] wcnt;
    logic [23:0] base;
    logic [23:0] next_ptr;
    logic [15:0] last_word;
    logic [15:0] last_count;
    logic done_flag;
    logic done_pend;
    rds_pkg::rds_mem_t mem;
    logic rx_done;
    logic cfg_purity;
    logic cfg_long_preamble_check;
    logic cfg_buffull;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
  } rds_regs_t;

  rds_regs_t r;
  rds_regs_t next_r;

  function automatic logic [31:0] crc_nibble(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] v;
    v = c;
    for (int i = 0; i < 4; i++) begin
      v = (v[0] ^ d[i]) ? ((v >> 1) ^ 32'hEDB88320) : (v >> 1);
    end
    return v;
  endfunction : crc_nibble

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction : addr_hit

  logic [7:0] byte_now;
  logic byte_done;
  logic good;
  logic [15:0] data_len;
  logic ovr_set;

  always_comb begin
    next_r = r;
    // done pulse trails the last descriptor byte by one cycle
    next_r.rx_done = r.done_pend;
    next_r.done_pend = 1'b0;
    next_r.mem.valid = 1'b0;
    ovr_set = 1'b0;
    if (r.done_pend) begin
      next_r.done_flag = 1'b1;
    end
    byte_now = {i_mii.data, r.lo_nib};
    byte_done = r.nib[0];
    good = 1'b0;
    data_len = r.bytes - rds_pkg::HDR_AND_FCS;
    // carrier event outside a frame
    if (!i_mii.dv && i_mii.er && i_mii.data == rds_pkg::CARRIER_CODE) begin
      next_r.carrier_seen = 1'b1;
    end
    case (r.fsm)
      rds_pkg::RDS_IDLE: begin
        if (r.gap != 5'h1F) begin
          next_r.gap = r.gap + 5'h01;
        end
        if (i_mii.dv) begin
          next_r.crc = 32'hFFFF_FFFF;
          next_r.nib = 16'h0000;
          next_r.pre_nib = 5'h01;
          next_r.bytes = 16'h0000;
          next_r.pre_impure = (i_mii.data != rds_pkg::PRE_NIBBLE);
          next_r.st = 16'h0000;
          next_r.st[rds_pkg::ST_LONG_DROP] = (r.gap < rds_pkg::MIN_GAP_NIBBLES);
          next_r.st[rds_pkg::ST_CODE_VIOL] = i_mii.er;
          next_r.st[rds_pkg::ST_CARRIER] = r.carrier_seen;
          next_r.st[rds_pkg::ST_SHORT] = r.short_seen;
          next_r.carrier_seen = 1'b0;
          next_r.short_seen = 1'b0;
          if (r.overrun) begin
            next_r.fsm = rds_pkg::RDS_DISCARD;
          end else begin
            next_r.fsm = rds_pkg::RDS_PRE;
          end
        end
      end
      rds_pkg::RDS_PRE: begin
        if (!i_mii.dv) begin
          next_r.short_seen = 1'b1;
          next_r.gap = 5'h00;
          next_r.fsm = rds_pkg::RDS_IDLE;
        end else if (i_mii.data == rds_pkg::SFD_NIBBLE) begin
          if (r.pre_impure && r.cfg_purity) begin
            next_r.st[rds_pkg::ST_LONG_DROP] = 1'b1;
          end
          if (r.pre_nib > rds_pkg::MAX_PREAMBLE_NIBBLES && r.cfg_long_preamble_check) begin
            next_r.st[rds_pkg::ST_LONG_DROP] = 1'b1;
          end
          next_r.fsm = rds_pkg::RDS_DATA;
        end else begin
          if (i_mii.data != rds_pkg::PRE_NIBBLE) begin
            next_r.pre_impure = 1'b1;
          end
          if (r.pre_nib != 5'h1F) begin
            next_r.pre_nib = r.pre_nib + 5'h01;
          end
        end
        if (i_mii.er) begin
          next_r.st[rds_pkg::ST_CODE_VIOL] = 1'b1;
        end
      end
      rds_pkg::RDS_DATA: begin
        if (i_mii.dv) begin
          next_r.crc = crc_nibble(r.crc, i_mii.data);
          next_r.nib = r.nib + 16'h0001;
          if (r.nib >= rds_pkg::LONG_EVENT_NIBBLES) begin
            next_r.st[rds_pkg::ST_LONG_DROP] = 1'b1;
          end
          if (i_mii.er) begin
            next_r.st[rds_pkg::ST_CODE_VIOL] = 1'b1;
          end
          if (!byte_done) begin
            next_r.lo_nib = i_mii.data;
          end else begin
            next_r.bytes = r.bytes + 16'h0001;
            if (r.bytes == 16'h0000) begin
              next_r.st[rds_pkg::ST_MULTICAST] = byte_now[0];
              next_r.st[rds_pkg::ST_BROADCAST] = (byte_now == 8'hFF);
            end else if (r.bytes < 16'h0006 && byte_now != 8'hFF) begin
              next_r.st[rds_pkg::ST_BROADCAST] = 1'b0;
            end
            if (r.bytes == 16'h000C) begin
              next_r.b12 = byte_now;
            end
            if (r.bytes == 16'h000D) begin
              next_r.len_type = {r.b12, byte_now};
            end
            if (r.bytes == 16'h000E) begin
              next_r.opcode[15:8] = byte_now;
            end
            if (r.bytes == 16'h000F) begin
              next_r.opcode[7:0] = byte_now;
            end
            if (i_fifo_full && r.cfg_buffull) begin
              next_r.st[rds_pkg::ST_OVERRUN] = 1'b1;
              next_r.overrun = 1'b1;
              ovr_set = 1'b1;
            end
          end
        end else begin
          next_r.st[rds_pkg::ST_ODD_NIBBLE] = r.nib[0];
          next_r.st[rds_pkg::ST_FCS_FAULT] = (r.crc != rds_pkg::CRC_RESIDUE);
          next_r.st[rds_pkg::ST_CONTROL] = (r.len_type == rds_pkg::TYPE_CONTROL);
          next_r.st[rds_pkg::ST_PAUSE] = (r.len_type == rds_pkg::TYPE_CONTROL)
            && (r.opcode == rds_pkg::OPCODE_PAUSE);
          next_r.st[rds_pkg::ST_UNK_OPCODE] = (r.len_type == rds_pkg::TYPE_CONTROL)
            && (r.opcode != rds_pkg::OPCODE_PAUSE);
          next_r.st[rds_pkg::ST_TAGGED] = (r.len_type == rds_pkg::TYPE_VLAN);
          next_r.st[rds_pkg::ST_LEN_RANGE] = (r.len_type > rds_pkg::MAX_LENGTH_FIELD)
            && (r.len_type < rds_pkg::LENGTH_TYPE_LIMIT);
          next_r.st[rds_pkg::ST_LEN_MISMATCH] = (r.len_type <= rds_pkg::MAX_LENGTH_FIELD)
            && (r.len_type != data_len);
          good = !r.nib[0] && (r.crc == rds_pkg::CRC_RESIDUE)
            && !(|r.st[rds_pkg::ST_LONG_DROP:rds_pkg::ST_LONG_DROP])
            && !r.st[rds_pkg::ST_CODE_VIOL] && !r.st[rds_pkg::ST_OVERRUN]
            && (r.bytes >= rds_pkg::MIN_FRAME_BYTES)
            && !next_r.st[rds_pkg::ST_LEN_RANGE] && !next_r.st[rds_pkg::ST_LEN_MISMATCH];
          next_r.st[rds_pkg::ST_INTACT] = good;
          if (r.bytes < rds_pkg::MIN_FRAME_BYTES) begin
            next_r.short_seen = 1'b1;
          end
          next_r.next_ptr = r.base + {8'h00, r.bytes} + {21'h000000, rds_pkg::DESC_BYTES};
          next_r.wcnt = 3'h0;
          next_r.gap = 5'h00;
          next_r.fsm = rds_pkg::RDS_WRITE;
        end
      end
      rds_pkg::RDS_DISCARD: begin
        if (!i_mii.dv) begin
          next_r.gap = 5'h00;
          next_r.fsm = rds_pkg::RDS_IDLE;
        end
      end
      rds_pkg::RDS_WRITE: begin
        // descriptor: pointer (3), byte count (2), status (2)
        next_r.mem.valid = 1'b1;
        next_r.mem.addr = r.base + {21'h000000, r.wcnt};
        case (r.wcnt)
          3'h0: next_r.mem.data = r.next_ptr[7:0];
          3'h1: next_r.mem.data = r.next_ptr[15:8];
          3'h2: next_r.mem.data = r.next_ptr[23:16];
          3'h3: next_r.mem.data = r.bytes[7:0];
          3'h4: next_r.mem.data = r.bytes[15:8];
          3'h5: next_r.mem.data = r.st[7:0];
          default: next_r.mem.data = r.st[15:8];
        endcase
        next_r.wcnt = r.wcnt + 3'h1;
        if (r.wcnt == 3'h6) begin
          next_r.done_pend = 1'b1;
          next_r.last_word = r.st;
          next_r.last_count = r.bytes;
          next_r.base = r.next_ptr;
          next_r.fsm = rds_pkg::RDS_IDLE;
        end
        if (r.gap != 5'h1F) begin
          next_r.gap = r.gap + 5'h01;
        end
      end
      default: next_r.fsm = rds_pkg::RDS_IDLE;
    endcase

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    if (i_s_axi_awvalid && !r.aw_held && !r.bvalid) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && !r.w_held && !r.bvalid) begin
      next_r.w_held = 1'b1;
      next_r.w_data = i_s_axi_wdata;
      next_r.w_strb = i_s_axi_wstrb;
    end
    if (r.aw_held && r.w_held) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'h0;
      if (addr_hit(r.aw_addr, rds_pkg::ADDR_CONFIG)) begin
        if (r.w_strb[0]) begin
          next_r.cfg_purity = r.w_data[rds_pkg::CFG_PURITY_BIT];
          next_r.cfg_long_preamble_check = r.w_data[rds_pkg::CFG_LONG_PREAMBLE_CHECK_BIT];
          next_r.cfg_buffull = r.w_data[rds_pkg::CFG_BUFFULL_BIT];
        end
      end else if (addr_hit(r.aw_addr, rds_pkg::ADDR_STATUS)) begin
        // write one to clear; a same-cycle set wins
        if (r.w_strb[0] && r.w_data[rds_pkg::STAT_OVERRUN_BIT]
            && !ovr_set) begin
          next_r.overrun = 1'b0;
        end
        if (r.w_strb[0] && r.w_data[rds_pkg::STAT_DONE_BIT] && !next_r.rx_done) begin
          next_r.done_flag = 1'b0;
        end
      end else if (addr_hit(r.aw_addr, rds_pkg::ADDR_BASE_PTR)) begin
        if (r.fsm == rds_pkg::RDS_IDLE) begin
          next_r.base = r.w_data[23:0];
        end
      end else if (!addr_hit(r.aw_addr, rds_pkg::ADDR_LAST_WORD)
                   && !addr_hit(r.aw_addr, rds_pkg::ADDR_LAST_COUNT)
                   && !addr_hit(r.aw_addr, rds_pkg::ADDR_NEXT_PTR)) begin
        next_r.bresp = 2'h2;
      end
    end
    if (r.bvalid && i_s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (i_s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = 2'h0;
      next_r.rdata = 32'h0000_0000;
      if (addr_hit(i_s_axi_araddr, rds_pkg::ADDR_CONFIG)) begin
        next_r.rdata[rds_pkg::CFG_PURITY_BIT] = r.cfg_purity;
        next_r.rdata[rds_pkg::CFG_LONG_PREAMBLE_CHECK_BIT] = r.cfg_long_preamble_check;
        next_r.rdata[rds_pkg::CFG_BUFFULL_BIT] = r.cfg_buffull;
      end else if (addr_hit(i_s_axi_araddr, rds_pkg::ADDR_STATUS)) begin
        next_r.rdata[rds_pkg::STAT_OVERRUN_BIT] = r.overrun;
        next_r.rdata[rds_pkg::STAT_DONE_BIT] = r.done_flag;
      end else if (addr_hit(i_s_axi_araddr, rds_pkg::ADDR_LAST_WORD)) begin
        next_r.rdata[15:0] = r.last_word;
      end else if (addr_hit(i_s_axi_araddr, rds_pkg::ADDR_LAST_COUNT)) begin
        next_r.rdata[15:0] = r.last_count;
      end else if (addr_hit(i_s_axi_araddr, rds_pkg::ADDR_NEXT_PTR)) begin
        next_r.rdata[23:0] = r.next_ptr;
      end else if (addr_hit(i_s_axi_araddr, rds_pkg::ADDR_BASE_PTR)) begin
        next_r.rdata[23:0] = r.base;
      end else begin
        next_r.rresp = 2'h2;
      end
    end
    if (r.rvalid && i_s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;
      r.fsm <= rds_pkg::RDS_IDLE;
      r.gap <= 5'h1F;
      r.base <= rds_pkg::BASE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign o_mem = r.mem;
  assign o_rx_done = r.rx_done;
  assign o_s_axi_awready = !r.aw_held && !r.bvalid;
  assign o_s_axi_wready = !r.w_held && !r.bvalid;
  assign o_s_axi_bvalid = r.bvalid;
  assign o_s_axi_bresp = r.bresp;
  assign o_s_axi_arready = !r.rvalid;
  assign o_s_axi_rvalid = r.rvalid;
  assign o_s_axi_rdata = r.rdata;
  assign o_s_axi_rresp = r.rresp;

endmodule : rds_rx_status

// >>> verif/rds_rx_status_props.sv
`timescale 1ns/1ps
module rds_rx_status_props (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire rds_pkg::rds_mii_t i_mii,
  input wire rds_pkg::rds_mem_t o_mem,
  input wire logic o_rx_done,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid
);
  // ----------------------------------------
  // last two descriptor bytes: status hi, lo
  // ----------------------------------------
  logic [7:0] b1;
  logic [7:0] b2;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      b1 <= 8'h00;
      b2 <= 8'h00;
    end else if (o_mem.valid) begin
      b1 <= o_mem.data;
      b2 <= b1;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  AST_SEVEN: assert property ($rose(o_mem.valid) |-> o_mem.valid [*7] ##1 (!o_mem.valid && o_rx_done))
    else $error("descriptor burst is not seven bytes then done");
  AST_STEP: assert property (o_mem.valid && $past(o_mem.valid) |-> o_mem.addr == $past(o_mem.addr) + 24'h1)
    else $error("descriptor byte address did not step by one");
  AST_START: assert property ($rose(o_mem.valid) |-> !$past(i_mii.dv, 2) && $past(i_mii.dv, 3))
    else $error("descriptor write not two cycles after frame end");
  AST_INTACT: assert property (o_rx_done && b1[7] |-> b1[6:4] == 3'h0 && b2[5:3] == 3'h0 && !b2[0])
    else $error("intact flag set beside an error flag");
  AST_PAUSE: assert property (o_rx_done && b1[3] |-> b1[2])
    else $error("pause frame not marked as control frame");
  AST_OPCODE: assert property (o_rx_done && b2[6] |-> b1[2] && !b1[3])
    else $error("unknown opcode outside a non-pause control frame");
  AST_RV: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  AST_ARBLK: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read address accepted during answer");
  cover property (o_rx_done && b1[7]);
  cover property (o_rx_done && b1[4]);
  cover property (o_rx_done && b2[0]);
endmodule : rds_rx_status_props

bind rds_rx_status rds_rx_status_props u_rds_rx_status_props (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_mii(i_mii), .o_mem(o_mem), .o_rx_done(o_rx_done),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid)
);

// >>> verif/rds_phy_model.sv
`timescale 1ns/1ps
module rds_phy_model (
  input wire logic i_mclk,
  output rds_pkg::rds_mii_t o_mii
);
  // ----------------------------------------
  // frame bytes, low nibble sent first
  // ----------------------------------------
  logic [7:0] fq[$];
  logic [3:0] last;
  initial o_mii = '0;
  initial last = 4'h0;
  task automatic nib(input logic dv, input logic er, input logic [3:0] d);
    @(posedge i_mclk);
    o_mii <= {dv, er, d};
    last = d;
  endtask : nib
  // idle data shows the inverse so stale nibbles never pass
  task automatic rest();
    @(posedge i_mclk);
    o_mii <= {2'b00, ~last};
  endtask : rest
  function automatic logic [31:0] fcs();
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (fq[i]) begin
      c = c ^ {24'h0, fq[i]};
      repeat (8)
        c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction : fcs
  task automatic build(input logic [7:0] dst, input logic [15:0] tl, op, nd, input bit bad);
    logic [31:0] c;
    fq.delete();
    for (int i = 0; i < 6; i++)
      fq.push_back(i == 0 || dst == 8'hFF ? dst : 8'h00);
    for (int i = 0; i < 6; i++)
      fq.push_back(8'h02 + i[7:0]);
    fq.push_back(tl[15:8]);
    fq.push_back(tl[7:0]);
    for (int i = 0; i < nd; i++)
      fq.push_back(op != 16'h0 && i < 2 ? (i == 0 ? op[15:8] : op[7:0]) : i[7:0]);
    c = fcs();
    for (int i = 0; i < 4; i++)
      fq.push_back(c[8*i +: 8] ^ {7'h0, bad && i == 3});
  endtask : build
  task automatic send(input int pre, input logic [3:0] pv, input bit sfd, input bit odd,
                      input int er_at);
    for (int k = 0; k < pre; k++)
      nib(1'b1, 1'b0, k == 1 ? pv : rds_pkg::PRE_NIBBLE);
    if (sfd) begin
      nib(1'b1, 1'b0, rds_pkg::SFD_NIBBLE);
      foreach (fq[i]) begin
        nib(1'b1, i == er_at, fq[i][3:0]);
        nib(1'b1, 1'b0, fq[i][7:4]);
      end
      if (odd)
        nib(1'b1, 1'b0, 4'hA);
    end
    rest();
  endtask : send
  task automatic carrier();
    nib(1'b0, 1'b1, rds_pkg::CARRIER_CODE);
    rest();
  endtask : carrier
endmodule : rds_phy_model

// >>> verif/rds_rx_status_tb.sv
`timescale 1ns/1ps
module rds_rx_status_tb;
  logic i_mclk, i_arst_n, fifo_full, rx_done, pv;
  rds_pkg::rds_mii_t mii;
  rds_pkg::rds_mem_t mem;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [55:0] dsc;
  logic [23:0] fa, nxt;
  logic [15:0] st;
  int done_cnt, fail_count, checks_done, cycles, n0;
  rds_rx_status u_rds_rx_status (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_mii(mii),
    .i_fifo_full(fifo_full), .o_mem(mem), .o_rx_done(rx_done), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready));
  rds_phy_model u_rds_phy_model (.i_mclk(i_mclk), .o_mii(mii));
  // ----------------------------------------
  // clock, watchdog, descriptor monitor
  // ----------------------------------------
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      final_report();
    end
  end
  always @(negedge i_mclk) begin
    if (mem.valid) begin
      dsc <= {dsc[47:0], mem.data};
      if (!pv)
        fa <= mem.addr;
    end
    pv <= mem.valid;
    if (rx_done)
      done_cnt <= done_cnt + 1;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge i_mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(negedge i_mclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      resp = bresp;
      @(posedge i_mclk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ha, hr;
    hr = 1'b0;
    @(posedge i_mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr) begin
      @(negedge i_mclk);
      ha = arvalid && arready;
      hr = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge i_mclk);
      if (ha)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd
  // fl: 0 bad fcs, 1 rx error, 2 odd nibble, 3 impure, 4 long preamble,
  // 5 short gap, 6 carrier before, 7 short burst before
  task automatic tc(input logic [7:0] dst, input logic [15:0] tl, op, nd, input logic [7:0] fl,
                    input logic [2:0] cfg, input logic [15:0] m, x);
    int tgt;
    axi_wr(rds_pkg::ADDR_CONFIG, {29'h0, cfg});
    u_rds_phy_model.build(dst, tl, op, nd, fl[0]);
    tgt = done_cnt + 1 + fl[5];
    if (fl[7])
      u_rds_phy_model.send(6, rds_pkg::PRE_NIBBLE, 1'b0, 1'b0, -1);
    if (fl[6])
      u_rds_phy_model.carrier();
    if (fl[7] | fl[6])
      repeat (30) @(posedge i_mclk);
    if (fl[5]) begin
      u_rds_phy_model.send(15, rds_pkg::PRE_NIBBLE, 1'b1, 1'b0, -1);
      repeat (14) @(posedge i_mclk);
      nxt = nxt + {8'h0, nd} + 24'h19;
    end
    u_rds_phy_model.send(fl[4] ? 30 : 15, fl[3] ? 4'h7 : rds_pkg::PRE_NIBBLE, 1'b1, fl[2],
                         fl[1] ? 20 : -1);
    while (done_cnt < tgt)
      @(posedge i_mclk);
    chk({16'h0, dsc[23:16], dsc[31:24]}, {16'h0, nd + 16'h12});
    chk({8'h0, fa}, {8'h0, nxt});
    nxt = nxt + {8'h0, nd} + 24'h19;
    chk({8'h0, dsc[39:32], dsc[47:40], dsc[55:48]}, {8'h0, nxt});
    st = {dsc[7:0], dsc[15:8]};
    chk({16'h0, st & m}, {16'h0, x});
    repeat (30) @(posedge i_mclk);
    $display("test %0d done", done_cnt);
  endtask : tc
  initial begin
    i_mclk = 1'b0; i_arst_n = 1'b0; fifo_full = 1'b0; pv = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; dsc = 56'h0; fa = 24'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    done_cnt = 0; fail_count = 0; checks_done = 0; cycles = 0;
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    axi_rd(rds_pkg::ADDR_CONFIG);
    chk(rd, rds_pkg::CFG_RESET);
    axi_rd(rds_pkg::ADDR_BASE_PTR);
    chk(rd, {8'h0, rds_pkg::BASE_RESET});
    axi_rd(8'h3C);
    chk({30'h0, resp}, 32'h2);
    axi_wr(8'h3C, 32'h1);
    chk({30'h0, resp}, 32'h2);
    axi_wr(rds_pkg::ADDR_BASE_PTR, 32'h100);
    nxt = 24'h100;
    $display("test registers done");
    tc(8'hFF, 16'h800, 16'h0, 16'h2E, 8'h0, 3'h0, 16'hFFFF, 16'h8300);
    tc(8'h01, 16'h800, 16'h0, 16'h2E, 8'h1, 3'h0, 16'hFFFF, 16'h2200);
    tc(8'h01, 16'h8808, 16'h1, 16'h2E, 8'h0, 3'h0, 16'hFFFF, 16'h8E00);
    tc(8'h01, 16'h8808, 16'h2, 16'h2E, 8'h0, 3'h0, 16'hFFFF, 16'h8640);
    tc(8'h02, 16'h10, 16'h0, 16'h2E, 8'h0, 3'h0, 16'hFFFF, 16'h10);
    tc(8'h02, 16'h5EE, 16'h0, 16'h2E, 8'h0, 3'h0, 16'hFFFF, 16'h10);
    tc(8'h02, 16'h5EF, 16'h0, 16'h2E, 8'h0, 3'h0, 16'hFFFF, 16'h20);
    tc(8'h02, 16'h800, 16'h0, 16'h2E, 8'h2, 3'h0, 16'hFFFF, 16'h8);
    tc(8'h02, 16'h800, 16'h0, 16'h2E, 8'h4, 3'h0, 16'hC000, 16'h4000);
    tc(8'h02, 16'h800, 16'h0, 16'h2E, 8'h8, 3'h1, 16'h9000, 16'h1000);
    tc(8'h02, 16'h800, 16'h0, 16'h2E, 8'h8, 3'h0, 16'hFFFF, 16'h8000);
    tc(8'h02, 16'h800, 16'h0, 16'h2E, 8'h10, 3'h2, 16'h9000, 16'h1000);
    tc(8'h02, 16'h800, 16'h0, 16'h2E, 8'h20, 3'h0, 16'h1000, 16'h1000);
    tc(8'h02, 16'h800, 16'h0, 16'h2E, 8'h40, 3'h0, 16'h4, 16'h4);
    tc(8'h02, 16'h800, 16'h0, 16'h2E, 8'h80, 3'h0, 16'h2, 16'h2);
    tc(8'h02, 16'h800, 16'h0, 16'h189C, 8'h0, 3'h0, 16'h9000, 16'h1000);
    tc(8'h02, 16'h8100, 16'h0, 16'h2E, 8'h0, 3'h2, 16'hFFFF, 16'h8080);
    axi_rd(rds_pkg::ADDR_LAST_WORD);
    chk(rd, 32'h8080);
    axi_rd(rds_pkg::ADDR_LAST_COUNT);
    chk(rd, 32'h40);
    axi_rd(rds_pkg::ADDR_NEXT_PTR);
    chk(rd, {8'h0, nxt});
    fifo_full <= 1'b1;
    tc(8'hFF, 16'h800, 16'h0, 16'h2E, 8'h0, 3'h4, 16'h8001, 16'h1);
    fifo_full <= 1'b0;
    n0 = done_cnt;
    u_rds_phy_model.send(15, rds_pkg::PRE_NIBBLE, 1'b1, 1'b0, -1);
    repeat (40) @(posedge i_mclk);
    chk(done_cnt, n0);
    axi_rd(rds_pkg::ADDR_STATUS);
    chk(rd, 32'h3);
    axi_wr(rds_pkg::ADDR_STATUS, 32'h1);
    axi_rd(rds_pkg::ADDR_STATUS);
    chk(rd, 32'h2);
    tc(8'hFF, 16'h800, 16'h0, 16'h2E, 8'h0, 3'h4, 16'hFFFF, 16'h8300);
    final_report();
  end
endmodule : rds_rx_status_tb
